/* shared/cpa_pkg.sv */
// Constants, types and the averaging decode function for the current/power accumulator
package cpa_pkg;
    // ----------------------------------------------------------------
    // Widths
    // ----------------------------------------------------------------
    localparam int ADC_W = 16;
    localparam int CAL_W = 15;
    localparam int CUR_W = 24;
    localparam int PWR_W = 24;
    localparam int AVG_SEL_W = 3;
    localparam int AVG_LOG2_DEF = 10;
    localparam int CNT_W = AVG_LOG2_DEF + 1;
    localparam int ACC_W = CUR_W + AVG_LOG2_DEF;
    localparam int ACC_T_W = ADC_W + AVG_LOG2_DEF;
    // Product widths and the bit positions taken from them
    localparam int PROD_C_W = ADC_W + CAL_W + 1;
    localparam int CUR_LSB = PROD_C_W - CUR_W;
    localparam int PROD_P_W = CUR_W + ADC_W + 1;
    localparam int PWR_LSB = PROD_P_W - 1 - PWR_W;
    // ----------------------------------------------------------------
    // Mode and channel codes, reset values
    // ----------------------------------------------------------------
    localparam logic [1:0] MODE_SHUTDOWN = 2'h0;
    localparam logic [1:0] MODE_TRIGGERED = 2'h1;
    localparam logic [1:0] MODE_CONTINUOUS = 2'h2;
    localparam logic [1:0] CH_SHUNT = 2'h0;
    localparam logic [1:0] CH_BUS = 2'h1;
    localparam logic [1:0] CH_TEMP = 2'h2;
    localparam logic [CNT_W-1:0] CNT_RESET = 11'h000;

    // Sequencer states, one-hot
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_SHUNT = 4'h2,
        ST_BUS = 4'h4,
        ST_TEMP = 4'h8
    } cpa_state_t;

    // Averaging select to log2 of the sample count: 1,4,16,64..1024
    function automatic logic [3:0] cpa_avg_log2(input logic [2:0] sel);
        case (sel)
            3'h0: cpa_avg_log2 = 4'h0;
            3'h1: cpa_avg_log2 = 4'h2;
            3'h2: cpa_avg_log2 = 4'h4;
            3'h3: cpa_avg_log2 = 4'h6;
            3'h4: cpa_avg_log2 = 4'h7;
            3'h5: cpa_avg_log2 = 4'h8;
            3'h6: cpa_avg_log2 = 4'h9;
            default: cpa_avg_log2 = 4'ha;
        endcase
    endfunction : cpa_avg_log2
endpackage : cpa_pkg

/* shared/cpa_calc_if.sv */
// Handshake carrying one shunt/bus pair into the arithmetic engine
`timescale 1ns/10ps
interface cpa_calc_if;
    import cpa_pkg::*;
    logic start;
    logic signed [ADC_W-1:0] shunt;
    logic [ADC_W-1:0] vbus;
    logic [CAL_W-1:0] cal;
    logic signed [CUR_W-1:0] current;
    logic signed [PWR_W-1:0] power;
    logic valid;
    modport ctrl(output start, shunt, vbus, cal,
        input current, power, valid);
    modport calc(input start, shunt, vbus, cal,
        output current, power, valid);
endinterface : cpa_calc_if

/* src/cpa_mult.sv */
// Current and power arithmetic engine, one result per start pulse
`timescale 1ns/10ps
module cpa_mult
    import cpa_pkg::*;
(
    input wire logic clk_in,
    input wire logic reset_in,
    cpa_calc_if.calc calc
);
    typedef struct packed {
        logic signed [CUR_W-1:0] cur;
        logic signed [PWR_W-1:0] pwr;
        logic signed [CUR_W-1:0] prev;
        logic valid;
    } cpa_mult_t;

    cpa_mult_t r_reg, r_next;
    logic signed [PROD_C_W-1:0] prod_c;
    logic signed [PROD_P_W-1:0] prod_p;

    // ----------------------------------------------------------------
    // Arithmetic
    // ----------------------------------------------------------------
    // Power uses the current held from the preceding calculation
    always_comb begin
        prod_c = calc.shunt * $signed({1'b0, calc.cal});
        prod_p = r_reg.prev * $signed({1'b0, calc.vbus});
        r_next = r_reg;
        r_next.valid = 1'b0;
        if (calc.start) begin
            r_next.cur = prod_c[PROD_C_W-1:CUR_LSB];
            r_next.prev = prod_c[PROD_C_W-1:CUR_LSB];
            // Zero calibration forces zero power, even from a stale current
            if (calc.cal == '0) begin
                r_next.pwr = '0;
            end else begin
                r_next.pwr = prod_p[PWR_LSB+PWR_W-1:PWR_LSB];
            end
            r_next.valid = 1'b1;
        end
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    assign calc.current = r_reg.cur;
    assign calc.power = r_reg.pwr;
    assign calc.valid = r_reg.valid;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    zero_cal_power_a: assert property (
        @(posedge clk_in) disable iff (reset_in)
        calc.start && calc.cal == '0 |=> calc.valid && calc.power == '0)
        else $error("power not zero with zero calibration");
    // Current shown at the start edge is the preceding result; widen it
    // before the multiply so the upper product bits are not lost
    prev_current_a: assert property (
        @(posedge clk_in) disable iff (reset_in)
        calc.start && calc.cal != '0 |=> calc.power ==
        PWR_W'((PROD_P_W'($past(calc.current))
        * $signed({1'b0, $past(calc.vbus)})) >>> PWR_LSB))
        else $error("power not from preceding current");
endmodule : cpa_mult

/* src/cpa_top.sv */
// Conversion sequencer with background current/power averaging
`timescale 1ns/10ps
// Contract
// - New current and power after shunt plus bus
// - Power uses previous current times latest bus
// - Zero calibration gives zero power
// - Averaging above one keeps partial sums internal
// - Every sample adds into the accumulator
// - Finished run loads averages into outputs
// - Arithmetic overlaps conversion, no added time
// - One multiplexed ADC, channels converted singly
// - Continuous and triggered modes both calculate
// - Averaging 1 to 1024, same for all
// - Outputs hold until next complete result
module cpa_top
    import cpa_pkg::*;
#(
    parameter int AVG_LOG2_MAX = AVG_LOG2_DEF
) (
    input wire logic CLK_SYS_IN,
    input wire logic RESET_IN,
    input wire logic [1:0] MODE_IN,
    input wire logic START_IN,
    input wire logic [AVG_SEL_W-1:0] AVG_SEL_IN,
    input wire logic [CAL_W-1:0] SHUNT_CAL_IN,
    input wire logic ADC_DONE_IN,
    input wire logic [ADC_W-1:0] ADC_DATA_IN,
    output logic [1:0] CHAN_SEL_OUT,
    output logic CONV_START_OUT,
    output logic BUSY_OUT,
    output logic signed [CUR_W-1:0] CURRENT_OUT,
    output logic signed [PWR_W-1:0] POWER_OUT,
    output logic signed [ADC_W-1:0] TEMP_OUT,
    output logic RESULT_READY_OUT
);
    // ----------------------------------------------------------------
    // Elaboration check
    // ----------------------------------------------------------------
    // Accumulators are sized for 1024 samples; more would overflow them
    if (AVG_LOG2_MAX < 1 || AVG_LOG2_MAX > AVG_LOG2_DEF) begin : g_chk
        $error("AVG_LOG2_MAX out of range");
    end

    typedef struct packed {
        cpa_state_t st;
        logic [1:0] chan;
        logic conv;
        logic busy;
        logic pend;
        logic calc_go;
        logic signed [ADC_W-1:0] shunt;
        logic [ADC_W-1:0] vbus;
        logic [CNT_W-1:0] cnt;
        logic signed [ACC_W-1:0] acc_c;
        logic signed [ACC_W-1:0] acc_p;
        logic signed [ACC_T_W-1:0] acc_t;
        logic signed [CUR_W-1:0] cur_o;
        logic signed [PWR_W-1:0] pwr_o;
        logic signed [ADC_W-1:0] tmp_o;
        logic rdy;
    } cpa_top_t;

    cpa_top_t r_reg, r_next;
    cpa_calc_if calc_bus();
    logic [3:0] sh;
    logic [CNT_W-1:0] last_cnt;
    logic signed [ACC_T_W-1:0] sum_t;

    // ----------------------------------------------------------------
    // Arithmetic engine
    // ----------------------------------------------------------------
    cpa_mult u_mult (
        .clk_in(CLK_SYS_IN),
        .reset_in(RESET_IN),
        .calc(calc_bus.calc)
    );

    // Pair handed over the cycle after the bus sample lands
    assign calc_bus.start = r_reg.calc_go;
    assign calc_bus.shunt = r_reg.shunt;
    assign calc_bus.vbus = r_reg.vbus;
    assign calc_bus.cal = SHUNT_CAL_IN;

    // ----------------------------------------------------------------
    // Sequencer and accumulators
    // ----------------------------------------------------------------
    // Averaging count shared by all three channels, clamped to the max
    always_comb begin
        sh = cpa_avg_log2(AVG_SEL_IN);
        if (sh > 4'(AVG_LOG2_MAX)) begin
            sh = 4'(AVG_LOG2_MAX);
        end
        last_cnt = (CNT_W'(1) << sh) - CNT_W'(1);
        sum_t = r_reg.acc_t + ACC_T_W'($signed(ADC_DATA_IN));
        r_next = r_reg;
        r_next.conv = 1'b0;
        r_next.calc_go = 1'b0;
        r_next.rdy = 1'b0;
        // Result lands during the temperature conversion, off the path
        if (calc_bus.valid && r_reg.pend) begin
            r_next.acc_c = r_reg.acc_c + ACC_W'(calc_bus.current);
            r_next.acc_p = r_reg.acc_p + ACC_W'(calc_bus.power);
            r_next.pend = 1'b0;
        end
        case (r_reg.st)
            ST_IDLE: begin
                r_next.busy = 1'b0;
            end
            ST_SHUNT: begin
                if (ADC_DONE_IN) begin
                    r_next.shunt = $signed(ADC_DATA_IN);
                    r_next.st = ST_BUS;
                    r_next.chan = CH_BUS;
                    r_next.conv = 1'b1;
                end
            end
            ST_BUS: begin
                if (ADC_DONE_IN) begin
                    r_next.vbus = ADC_DATA_IN;
                    r_next.calc_go = 1'b1;
                    r_next.pend = 1'b1;
                    r_next.st = ST_TEMP;
                    r_next.chan = CH_TEMP;
                    r_next.conv = 1'b1;
                end
            end
            ST_TEMP: begin
                if (ADC_DONE_IN) begin
                    r_next.acc_t = sum_t;
                    r_next.chan = CH_SHUNT;
                    if (r_reg.cnt == last_cnt) begin
                        // Whole run done: averages go out together
                        r_next.cur_o = CUR_W'(r_reg.acc_c >>> sh);
                        r_next.pwr_o = PWR_W'(r_reg.acc_p >>> sh);
                        r_next.tmp_o = ADC_W'(sum_t >>> sh);
                        r_next.rdy = 1'b1;
                        r_next.acc_c = '0;
                        r_next.acc_p = '0;
                        r_next.acc_t = '0;
                        r_next.cnt = CNT_RESET;
                        if (MODE_IN == MODE_CONTINUOUS) begin
                            r_next.st = ST_SHUNT;
                            r_next.conv = 1'b1;
                        end else begin
                            r_next.st = ST_IDLE;
                            r_next.busy = 1'b0;
                        end
                    end else begin
                        // Partial sums stay internal until the last sample
                        r_next.cnt = r_reg.cnt + CNT_W'(1);
                        r_next.st = ST_SHUNT;
                        r_next.conv = 1'b1;
                    end
                end
            end
            default: begin
                r_next.st = ST_IDLE;
            end
        endcase
        // A mode write aborts any run; a result in flight is discarded
        if (START_IN) begin
            r_next.acc_c = '0;
            r_next.acc_p = '0;
            r_next.acc_t = '0;
            r_next.cnt = CNT_RESET;
            r_next.pend = 1'b0;
            r_next.calc_go = 1'b0;
            r_next.rdy = 1'b0;
            r_next.chan = CH_SHUNT;
            if (MODE_IN == MODE_SHUTDOWN) begin
                r_next.st = ST_IDLE;
                r_next.busy = 1'b0;
                r_next.conv = 1'b0;
            end else begin
                r_next.st = ST_SHUNT;
                r_next.busy = 1'b1;
                r_next.conv = 1'b1;
            end
        end
    end

    always_ff @(posedge CLK_SYS_IN) begin
        if (RESET_IN) begin
            r_reg <= '0;
            r_reg.st <= ST_IDLE;
        end else begin
            r_reg <= r_next;
        end
    end

    // ----------------------------------------------------------------
    // Outputs, all straight from the state register
    // ----------------------------------------------------------------
    // Reads never touch these, so they hold until the next load
    assign CHAN_SEL_OUT = r_reg.chan;
    assign CONV_START_OUT = r_reg.conv;
    assign BUSY_OUT = r_reg.busy;
    assign CURRENT_OUT = r_reg.cur_o;
    assign POWER_OUT = r_reg.pwr_o;
    assign TEMP_OUT = r_reg.tmp_o;
    assign RESULT_READY_OUT = r_reg.rdy;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge CLK_SYS_IN); endclocking
    default disable iff (RESET_IN);

    calc_after_bus_a: assert property (
        r_reg.st == ST_BUS && ADC_DONE_IN && !START_IN
        |=> calc_bus.start ##1 calc_bus.valid)
        else $error("no calculation after bus sample");
    acc_holds_a: assert property (
        !RESULT_READY_OUT && !START_IN && !(calc_bus.valid && r_reg.pend)
        && !(r_reg.st == ST_TEMP && ADC_DONE_IN) |=> $stable(r_reg.acc_c))
        else $error("accumulator moved without a sample");
    acc_add_a: assert property (
        calc_bus.valid && r_reg.pend && !START_IN |=>
        r_reg.acc_c == $past(r_reg.acc_c) + ACC_W'($past(calc_bus.current)))
        else $error("current not accumulated");
    run_load_a: assert property (
        r_reg.st == ST_TEMP && ADC_DONE_IN && r_reg.cnt == last_cnt
        && !START_IN |=> RESULT_READY_OUT && CURRENT_OUT ==
        CUR_W'($past(r_reg.acc_c) >>> $past(sh)))
        else $error("average not loaded at end of run");
    calc_in_time_a: assert property (
        r_reg.st == ST_TEMP && ADC_DONE_IN |-> !r_reg.pend)
        else $error("calculation lengthened the sequence");
    // A start on the same edge legally relaunches the shunt conversion
    single_chan_a: assert property (
        CONV_START_OUT && !START_IN |-> $onehot(r_reg.st)
        && CHAN_SEL_OUT != 2'h3 ##1 !CONV_START_OUT)
        else $error("bad channel sequencing");
    mode_loop_a: assert property (
        RESULT_READY_OUT && MODE_IN == MODE_CONTINUOUS && $past(MODE_IN)
        == MODE_CONTINUOUS && !$past(START_IN)
        |-> CONV_START_OUT && CHAN_SEL_OUT == CH_SHUNT)
        else $error("continuous mode did not restart");
    cnt_bound_a: assert property (
        r_reg.cnt <= last_cnt || $changed(AVG_SEL_IN))
        else $error("sample count beyond averaging setting");
    out_hold_a: assert property (
        !RESULT_READY_OUT |-> $stable(CURRENT_OUT) && $stable(POWER_OUT))
        else $error("output changed without a result");
    run_clear_a: assert property (
        START_IN |=> r_reg.acc_c == '0 && r_reg.acc_p == '0
        && r_reg.cnt == CNT_RESET)
        else $error("accumulator not cleared at run start");

    avg_run_c: cover property (RESULT_READY_OUT && AVG_SEL_IN != 3'h0);
    trig_done_c: cover property (RESULT_READY_OUT
        && MODE_IN == MODE_TRIGGERED ##1 !BUSY_OUT);
    zero_cal_c: cover property (calc_bus.start && SHUNT_CAL_IN == '0);
    restart_c: cover property (START_IN && r_reg.st == ST_TEMP);
endmodule : cpa_top

/* tb/cpa_adc_model.sv */
// Behavioural multiplexed ADC answering the sequencer's conversion starts
`timescale 1ns/10ps
module cpa_adc_model
    import cpa_pkg::*;
(
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic conv_start_in,
    input wire logic [1:0] chan_sel_in,
    input wire logic [3:0] lat_in,
    input wire logic [ADC_W-1:0] shunt_in,
    input wire logic [ADC_W-1:0] vbus_in,
    input wire logic [ADC_W-1:0] temp_in,
    output logic done_out,
    output logic [ADC_W-1:0] data_out,
    output logic [7:0] err_out
);
    logic pend_reg;
    logic [3:0] cnt_reg;
    logic [1:0] ch_reg;
    logic [1:0] next_reg;

    // ----------------------------------------------------------------
    // Conversion engine
    // ----------------------------------------------------------------
    // One channel at a time; only a fresh shunt start may cut in, as a
    // restart does. Latency lat_in lets the bench run prompt or slow.
    always_ff @(posedge clk_in) begin
        done_out <= 1'b0;
        data_out <= ~data_out; // Idle data inverts every cycle, so the last sample shows again on every other cycle
        if (reset_in) begin
            pend_reg <= 1'b0;
            next_reg <= CH_SHUNT;
            data_out <= 16'h5a5a;
            err_out <= 8'h00;
        end else if (conv_start_in) begin
            if ((pend_reg || chan_sel_in != next_reg)
                    && chan_sel_in != CH_SHUNT) begin
                err_out <= err_out + 8'h01;
            end
            pend_reg <= 1'b1;
            cnt_reg <= lat_in;
            ch_reg <= chan_sel_in;
            next_reg <= (chan_sel_in == CH_TEMP) ? CH_SHUNT
                : chan_sel_in + 2'h1;
        end else if (pend_reg) begin
            if (cnt_reg <= 4'h1) begin
                done_out <= 1'b1;
                pend_reg <= 1'b0;
                data_out <= (ch_reg == CH_SHUNT) ? shunt_in
                    : (ch_reg == CH_BUS) ? vbus_in : temp_in;
            end else begin
                cnt_reg <= cnt_reg - 4'h1;
            end
        end
    end
endmodule : cpa_adc_model

/* tb/current_power_accumulator_tb.sv */
// Self-checking bench for the current/power accumulator
`timescale 1ns/10ps
module current_power_accumulator_tb;
    import cpa_pkg::*;
    typedef struct packed {
        logic [2:0] sel;
        logic [3:0] lat;
        logic [CAL_W-1:0] cal;
        logic [ADC_W-1:0] sh;
        logic [ADC_W-1:0] vb;
        logic [ADC_W-1:0] tp;
    } cpa_row_t;
    logic clk, rst, start, done, busy, ready, conv, moved;
    logic [1:0] mode, chan;
    logic [2:0] avg_sel;
    logic [3:0] lat;
    logic [CAL_W-1:0] cal;
    logic [ADC_W-1:0] data, m_sh, m_vb, m_tp;
    logic signed [CUR_W-1:0] cur, prev_cur, hold_c, c2;
    logic signed [PWR_W-1:0] pwr, hold_p;
    logic signed [ADC_W-1:0] temp;
    logic [7:0] err;
    int mismatches, checks_done, n;
    int lg2 [8] = '{0, 2, 4, 6, 7, 8, 9, 10};
    // Ordinary cases: avg select, ADC latency, cal, shunt, bus, temp
    cpa_row_t rows [6] = '{
        '{3'h0, 4'h1, 15'h1000, 16'h0400, 16'h1000, 16'h0c80},
        '{3'h0, 4'h3, 15'h1000, 16'hfc00, 16'h8000, 16'h0c80},
        '{3'h1, 4'h2, 15'h7fff, 16'h7fff, 16'hffff, 16'hff00},
        '{3'h0, 4'h1, 15'h0000, 16'h1234, 16'h2000, 16'h0010},
        '{3'h7, 4'h1, 15'h0100, 16'h8000, 16'h0010, 16'hfff0},
        '{3'h2, 4'h4, 15'h0040, 16'hff80, 16'h4000, 16'h0200}};
    cpa_row_t rc = '{3'h3, 4'h1, 15'h0800, 16'h0300, 16'h7000, 16'h0123};

    cpa_top #(.AVG_LOG2_MAX(10)) cpa_top_i (
        .CLK_SYS_IN(clk), .RESET_IN(rst), .MODE_IN(mode),
        .START_IN(start), .AVG_SEL_IN(avg_sel), .SHUNT_CAL_IN(cal),
        .ADC_DONE_IN(done), .ADC_DATA_IN(data), .CHAN_SEL_OUT(chan),
        .CONV_START_OUT(conv), .BUSY_OUT(busy), .CURRENT_OUT(cur),
        .POWER_OUT(pwr), .TEMP_OUT(temp), .RESULT_READY_OUT(ready));
    cpa_adc_model cpa_adc_model_i (
        .clk_in(clk), .reset_in(rst), .conv_start_in(conv),
        .chan_sel_in(chan), .lat_in(lat), .shunt_in(m_sh),
        .vbus_in(m_vb), .temp_in(m_tp), .done_out(done),
        .data_out(data), .err_out(err));

    // ----------------------------------------------------------------
    // Checking and closing
    // ----------------------------------------------------------------
    task automatic chk(input string what, input logic [63:0] seen, exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic final_report();
        $display("checks_done %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : final_report
    // Reference arithmetic, kept apart from the design's own code
    function automatic logic signed [23:0] cur_of(input logic [15:0] s,
            input logic [14:0] k);
        logic signed [31:0] p;
        p = $signed(s) * $signed({1'b0, k});
        return p[31:8];
    endfunction : cur_of
    function automatic logic signed [23:0] pwr_of(
            input logic signed [23:0] c, input logic [15:0] v);
        logic signed [40:0] q;
        q = c * $signed({1'b0, v});
        return q[39:16];
    endfunction : pwr_of
    task automatic kick(input cpa_row_t r, input logic [1:0] md);
        avg_sel = r.sel;
        lat = r.lat;
        cal = r.cal;
        {m_sh, m_vb, m_tp} = {r.sh, r.vb, r.tp};
        mode = md;
        start = 1'b1;
        @(posedge clk);
        #1;
        start = 1'b0;
    endtask : kick
    // Bounded wait for a result, watching that outputs hold meanwhile
    task automatic wait_ready(output int k);
        k = 0;
        {hold_c, hold_p, moved} = {cur, pwr, 1'b0};
        do begin
            @(posedge clk);
            #1;
            k++;
            if (ready !== 1'b1 && (cur !== hold_c || pwr !== hold_p))
                moved = 1'b1;
        end while (ready !== 1'b1 && k < 20000);
        if (k >= 20000) begin
            mismatches++;
            final_report();
        end
    endtask : wait_ready
    task automatic run_row(input cpa_row_t r, input logic [1:0] md);
        logic signed [CUR_W-1:0] c, p0, p1;
        logic signed [63:0] ps;
        int nn;
        c = cur_of(r.sh, r.cal);
        p0 = (r.cal == 0) ? '0 : pwr_of(prev_cur, r.vb);
        p1 = (r.cal == 0) ? '0 : pwr_of(c, r.vb);
        nn = 1 << lg2[r.sel];
        ps = (p0 + (nn - 1) * p1) >>> lg2[r.sel];
        kick(r, md);
        wait_ready(n);
        chk("cycles", n, 3 * nn * (r.lat + 2));
        chk("current", cur, c);
        chk("power", pwr, $signed(ps[23:0]));
        chk("temp", temp, $signed(r.tp));
        chk("held", moved, 1'b0);
        chk("busy", busy, md == MODE_CONTINUOUS);
        prev_cur = c;
        @(posedge clk);
        #1;
        chk("pulse", ready, 1'b0);
    endtask : run_row

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        {start, mode, avg_sel, cal, lat, m_sh, m_vb, m_tp} = '0;
        {mismatches, checks_done, prev_cur} = '0;
        rst = 1'b1;
        repeat (12) @(posedge clk);
        #1;
        chk("reset flags", {busy, ready, conv}, 3'h0);
        chk("reset data", {cur, pwr, temp}, 64'h0);
        rst = 1'b0;
        @(posedge clk);
        #1;
        foreach (rows[i]) run_row(rows[i], MODE_TRIGGERED);
        // Restart lands on a done pulse; old partial sums must vanish
        kick('{3'h1, 4'h1, 15'h2000, 16'h0800, 16'h0000, 16'h0100},
            MODE_TRIGGERED);
        repeat (20) @(posedge clk);
        #1;
        run_row('{3'h1, 4'h1, 15'h2000, 16'hf000, 16'h0000, 16'h0100},
            MODE_TRIGGERED);
        // Free-running mode keeps looping with the same averaging
        run_row(rc, MODE_CONTINUOUS);
        c2 = cur_of(rc.sh, rc.cal);
        wait_ready(n);
        chk("loop cycles", n, 575);
        chk("loop power", pwr, pwr_of(c2, rc.vb));
        chk("loop busy", busy, 1'b1);
        // Stop mid-conversion; the late done must be ignored
        kick(rc, MODE_SHUTDOWN);
        chk("stop busy", busy, 1'b0);
        {hold_c, hold_p, moved} = {cur, pwr, 1'b0};
        repeat (30) begin
            @(posedge clk);
            #1;
            if (ready !== 1'b0 || conv !== 1'b0 || cur !== hold_c
                    || pwr !== hold_p)
                moved = 1'b1;
        end
        chk("stop held", moved, 1'b0);
        chk("adc order", err, 8'h00);
        final_report();
    end
endmodule : current_power_accumulator_tb
